/* File: inc/psp_bus_if.sv */
// Interface joining the memory controller and the memory device.
// Resolves the shared data wire here from the device enable alone.
`default_nettype none
interface psp_bus_if;
  import psp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic load_advance_n;
  logic write_n;
  logic [LANES-1:0] byte_lane_write_n;
  logic chip_select_a_n;
  logic chip_select_hi;
  logic chip_select_b_n;
  logic clock_gate_n;
  logic linear_order;
  logic sleep_request;
  logic [DATA_W-1:0] dq_ctl;
  logic dq_ctl_oe_n;
  logic [DATA_W-1:0] dq_dev;
  logic dq_dev_oe_n;
  logic [DATA_W-1:0] dq;
  assign dq = !dq_dev_oe_n ? dq_dev : dq_ctl;
  modport device (input addr, load_advance_n, write_n, byte_lane_write_n,
    chip_select_a_n, chip_select_hi, chip_select_b_n, clock_gate_n,
    linear_order, sleep_request, dq, output dq_dev, dq_dev_oe_n);
  modport ctrl (output addr, load_advance_n, write_n, byte_lane_write_n,
    chip_select_a_n, chip_select_hi, chip_select_b_n, clock_gate_n,
    linear_order, sleep_request, dq_ctl, dq_ctl_oe_n, input dq);
endinterface : psp_bus_if
`default_nettype wire

/* File: inc/psp_pkg.sv */
// Package for the pipelined synchronous static memory port.
// Assumes one clock shared by the device end and the controller end.
`default_nettype none
package psp_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DEPTH = 256;
  localparam int MEM_AW = 8;
  // Cycles from the accepting edge to the data beat.
  localparam int DATA_LAT = 2;
  localparam logic [1:0] BURST_LEN_M1 = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
  typedef enum logic [1:0] {PSP_OP_IDLE, PSP_OP_READ, PSP_OP_WRITE} psp_op_t;
  // Next word in a four-word burst.
  function automatic logic [1:0] psp_burst_next(input logic [1:0] base,
      input logic [1:0] cnt, input logic linear);
    logic [1:0] c;
    c = cnt + 2'h1;
    return linear ? 2'(base + c) : (base ^ c);
  endfunction
endpackage : psp_pkg
`default_nettype wire

/* File: rtl/psp_ctrl.sv */
// Controller end: issues single accesses or four-word bursts.
// Assumes the device returns data two active cycles after acceptance.
`default_nettype none
module psp_ctrl (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // User request.
  input wire logic REQ_VALID_IN,
  input wire logic REQ_WRITE_IN,
  input wire logic REQ_BURST_IN,
  input wire logic [psp_pkg::ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [psp_pkg::LANES-1:0] REQ_LANES_N_IN,
  input wire logic [psp_pkg::DATA_W-1:0] REQ_WDATA_IN,
  input wire logic LINEAR_IN,
  input wire logic SUSPEND_IN,
  input wire logic SLEEP_IN,
  output logic REQ_READY_OUT,
  // Read answer.
  output logic RD_VALID_OUT,
  output logic [psp_pkg::DATA_W-1:0] RD_DATA_OUT,
  // Link to the device.
  psp_bus_if.ctrl BUS
);
  import psp_pkg::*;
  typedef struct packed {
    logic [1:0] left;
    logic wr;
    logic rd1;
    logic rd2;
    logic rd3;
    logic wr1;
    logic [DATA_W-1:0] wd1;
    logic [DATA_W-1:0] dout;
    logic dout_oe_n;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic desel;
    logic wake;
  } psp_ctl_state_t;
  psp_ctl_state_t st, next_st;
  logic take;
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    // The device ignores loads while asleep or just waking, so hold off.
    REQ_READY_OUT = !SUSPEND_IN && st.left == 2'h0 && !SLEEP_IN &&
      !st.desel && !st.wake;
    take = REQ_VALID_IN && REQ_READY_OUT;
    if (!SUSPEND_IN) begin
      next_st.rd2 = st.rd1;
      next_st.rd3 = st.rd2;
      // Write data stands in the cycle before the device samples it.
      next_st.dout_oe_n = !st.wr1;
      next_st.dout = st.wd1;
      next_st.rvalid = st.rd3;
      if (st.rd3) begin
        next_st.rdata = BUS.dq;
      end
      next_st.rd1 = take ? !REQ_WRITE_IN : (st.left != 2'h0 && !st.wr);
      next_st.wr1 = take ? REQ_WRITE_IN : (st.left != 2'h0 && st.wr);
      next_st.wd1 = REQ_WDATA_IN;
      if (take) begin
        next_st.wr = REQ_WRITE_IN;
        next_st.left = REQ_BURST_IN ? BURST_LEN_M1 : 2'h0;
      end else if (st.left != 2'h0) begin
        next_st.left = st.left - 2'h1;
      end
      // Deselect one cycle ahead of sleep.
      next_st.desel = SLEEP_IN && !take && st.left == 2'h0;
      next_st.wake = st.desel;
    end
  end
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st <= '0;
      st.dout_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  assign BUS.addr = REQ_ADDR_IN;
  // Idle cycles are deselect cycles, so a high strobe always means a beat.
  assign BUS.load_advance_n = (st.left != 2'h0);
  assign BUS.write_n = !(take && REQ_WRITE_IN);
  assign BUS.byte_lane_write_n = REQ_LANES_N_IN;
  assign BUS.chip_select_a_n = !take;
  assign BUS.chip_select_hi = take;
  assign BUS.chip_select_b_n = !take;
  assign BUS.clock_gate_n = SUSPEND_IN;
  assign BUS.linear_order = LINEAR_IN;
  assign BUS.sleep_request = st.desel;
  assign BUS.dq_ctl = st.dout;
  assign BUS.dq_ctl_oe_n = st.dout_oe_n;
  assign RD_VALID_OUT = st.rvalid;
  assign RD_DATA_OUT = st.rdata;
endmodule // psp_ctrl
`default_nettype wire

/* File: rtl/psp_device.sv */
// Memory device end of the pipelined synchronous port.
// Assumes the controller keeps its own side of the protocol.
`default_nettype none
// Overview of operation
// - Low load strobe ends burst, loads address.
// - Read/write select ignored while burst continues.
// - Direction fixed at the loading edge.
// - Burst steps two low address bits.
// - Controller gives lane strobes every write beat.
// - Write starts when select and load low.
// - Lane strobes lead write data one cycle.
// - High clock gate freezes every register.
// - Any inactive chip select gives deselect.
// - Controller deselects before requesting sleep.
// - Data pins float while leaving sleep.
module psp_device (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Link to the controller.
  psp_bus_if.device BUS,
  // Status.
  output logic SLEEPING_OUT
);
  import psp_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [1:0] cnt;
    logic bursting;
    logic burst_wr;
    psp_op_t op1;
    logic [MEM_AW-1:0] a1;
    psp_op_t op2;
    logic [MEM_AW-1:0] a2;
    logic [LANES-1:0] lanes2;
    logic [DATA_W-1:0] q;
    logic q_oe_n;
    logic sleeping;
    logic waking;
  } psp_dev_state_t;
  psp_dev_state_t st, next_st;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [1:0] low;
  logic sel;
  logic do_write;
  always_comb begin
    next_st = st;
    sel = !BUS.chip_select_a_n && BUS.chip_select_hi && !BUS.chip_select_b_n;
    low = psp_burst_next(st.base[1:0], st.cnt, BUS.linear_order);
    do_write = 1'b0;
    if (!BUS.clock_gate_n) begin
      // Pipeline stage two: beat for the edge two cycles back.
      next_st.op2 = st.op1;
      next_st.a2 = st.a1;
      next_st.lanes2 = BUS.byte_lane_write_n;
      next_st.q_oe_n = 1'b1;
      if (st.op2 == PSP_OP_READ && !st.sleeping && !st.waking) begin
        next_st.q = mem[st.a2];
        next_st.q_oe_n = 1'b0;
      end
      do_write = (st.op2 == PSP_OP_WRITE);
      next_st.op1 = PSP_OP_IDLE;
      next_st.waking = st.sleeping && !BUS.sleep_request;
      next_st.sleeping = BUS.sleep_request;
      if (BUS.sleep_request || st.sleeping) begin
        next_st.bursting = 1'b0;
        next_st.q_oe_n = 1'b1;
      end else if (!BUS.load_advance_n) begin
        next_st.bursting = 1'b0;
        if (sel) begin
          next_st.base = BUS.addr;
          next_st.cnt = 2'h0;
          next_st.bursting = 1'b1;
          next_st.burst_wr = !BUS.write_n;
          next_st.op1 = !BUS.write_n ? PSP_OP_WRITE : PSP_OP_READ;
          next_st.a1 = BUS.addr[MEM_AW-1:0];
        end
      end else if (st.bursting && st.cnt != BURST_LEN_M1) begin
        // Direction comes from the loading edge only.
        next_st.cnt = st.cnt + 2'h1;
        next_st.op1 = st.burst_wr ? PSP_OP_WRITE : PSP_OP_READ;
        next_st.a1 = {st.base[MEM_AW-1:2], low};
      end else begin
        next_st.bursting = 1'b0;
      end
    end
  end
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st <= '{base: ADDR_RESET, cnt: 2'h0, bursting: 1'b0, burst_wr: 1'b0,
        op1: PSP_OP_IDLE, a1: '0, op2: PSP_OP_IDLE, a2: '0,
        lanes2: '1, q: '0, q_oe_n: 1'b1, sleeping: 1'b0, waking: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  // Memory array has no reset; contents are undefined until written.
  always_ff @(posedge CLK_IN) begin
    for (int g = 0; g < LANES; g++) begin
      if (do_write && !st.lanes2[g]) begin
        mem[st.a2][g*LANE_W +: LANE_W] <= BUS.dq[g*LANE_W +: LANE_W];
      end
    end
  end
  assign BUS.dq_dev = st.q;
  assign BUS.dq_dev_oe_n = st.q_oe_n;
  assign SLEEPING_OUT = st.sleeping;
endmodule // psp_device
`default_nettype wire

/* File: test/pipelined_sync_sram_port_test.sv */
// Bench joining controller and device through the shared interface.
// Assumes the interface resolves the data wire from the device enable.
`default_nettype none
module pipelined_sync_sram_port_test import psp_pkg::*;;
  timeunit 1ns / 1ps;
  typedef struct packed {
    logic w;
    logic [ADDR_W-1:0] a;
    logic [LANES-1:0] l;
    logic [DATA_W-1:0] d;
  } psp_row_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic v = 1'h0, w = 1'h0, b = 1'h0, lin = 1'h0, sus = 1'h0, slp = 1'h0;
  logic [ADDR_W-1:0] a = 18'h0;
  logic [LANES-1:0] l = 4'h0;
  logic [DATA_W-1:0] d = 36'h0;
  logic rdy, rv, slept;
  logic [DATA_W-1:0] rd;
  int bad_count = 0;
  int checks_done = 0;
  psp_row_t rows [6] = '{
    '{1'h1, 18'h00010, 4'h0, 36'h123456789},
    '{1'h0, 18'h00010, 4'h0, 36'h123456789},
    '{1'h1, 18'h00010, 4'hE, 36'hFFFFFFFFF},
    '{1'h0, 18'h00010, 4'h0, 36'h1234567FF},
    '{1'h1, 18'h3FF13, 4'h0, 36'hABCDEF012},
    '{1'h0, 18'h00013, 4'h0, 36'hABCDEF012}};
  always #2 clk = !clk;
  psp_bus_if bus();
  psp_device i_psp_device(.CLK_IN(clk), .RESET_N_IN(rst_n), .BUS(bus),
    .SLEEPING_OUT(slept));
  psp_ctrl i_psp_ctrl(.CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(v),
    .REQ_WRITE_IN(w), .REQ_BURST_IN(b), .REQ_ADDR_IN(a),
    .REQ_LANES_N_IN(l), .REQ_WDATA_IN(d), .LINEAR_IN(lin),
    .SUSPEND_IN(sus), .SLEEP_IN(slp), .REQ_READY_OUT(rdy),
    .RD_VALID_OUT(rv), .RD_DATA_OUT(rd), .BUS(bus));
  psp_asserts i_psp_asserts(.CLK_IN(clk), .RESET_N_IN(rst_n),
    .load_advance_n(bus.load_advance_n), .write_n(bus.write_n),
    .chip_select_a_n(bus.chip_select_a_n),
    .chip_select_hi(bus.chip_select_hi),
    .chip_select_b_n(bus.chip_select_b_n),
    .clock_gate_n(bus.clock_gate_n), .sleep_request(bus.sleep_request),
    .dq_dev(bus.dq_dev), .dq_dev_oe_n(bus.dq_dev_oe_n));
  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic req(input psp_row_t r, input logic bst);
    @(posedge clk);
    {v, w, b, a, l, d} <= {1'h1, r.w, bst, r.a, r.l, r.d};
    do @(negedge clk); while (!rdy);
    @(posedge clk);
    v <= 1'h0;
  endtask
  task automatic get(input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rv !== 1'h1 && n < 40);
    chk(rv, 1'h1);
    chk(rd, exp);
  endtask
  // Writes pause three cycles so the lane strobes hold until the data beat.
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    chk({slept, bus.dq_dev_oe_n}, 2'h1);
    foreach (rows[i]) begin
      req(rows[i], 1'h0);
      if (!rows[i].w) get(rows[i].d);
      else repeat (3) @(posedge clk);
    end
    for (int i = 0; i < 4; i++) begin
      req('{1'h1, 18'(8'h20 + i), 4'h0, 36'(12'h100 + i)}, 1'h0);
      repeat (3) @(posedge clk);
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) lin <= m[0];
      req('{1'h0, 18'h00021, 4'h0, 36'h0}, 1'h1);
      sus <= m[0];
      repeat (2) @(posedge clk);
      sus <= 1'h0;
      for (int k = 0; k < 4; k++) begin
        get(36'(12'h100 + (m ? 2'(1 + k) : 2'(1 ^ k))));
      end
    end
    @(posedge clk) slp <= 1'h1;
    repeat (8) @(negedge clk);
    chk(slept, 1'h1);
    @(posedge clk) slp <= 1'h0;
    repeat (8) @(negedge clk);
    chk(slept, 1'h0);
    req(rows[3], 1'h0);
    get(rows[3].d);
    conclude();
  end
  // The tests need well under a thousand cycles, so this margin is ample.
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
endmodule // pipelined_sync_sram_port_test
`default_nettype wire

/* File: test/psp_asserts.sv */
// Checker for the link between controller and device.
// Assumes one clock and the interface signals as plain inputs.
`default_nettype none
module psp_asserts
  import psp_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // Link signals.
  input wire logic load_advance_n,
  input wire logic write_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_hi,
  input wire logic chip_select_b_n,
  input wire logic clock_gate_n,
  input wire logic sleep_request,
  input wire logic [DATA_W-1:0] dq_dev,
  input wire logic dq_dev_oe_n
);
  timeunit 1ns / 1ps;
  logic sel;
  logic go;
  assign sel = !chip_select_a_n && chip_select_hi && !chip_select_b_n;
  assign go = !clock_gate_n && !load_advance_n && sel && !sleep_request;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  property p_rd; go && write_n ##1 !clock_gate_n && !sleep_request
    ##1 !clock_gate_n && !sleep_request |-> ##1 !dq_dev_oe_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read beat late");
  property p_wr; go && !write_n ##1 !clock_gate_n ##1 !clock_gate_n
    |-> ##1 dq_dev_oe_n; endproperty
  a_wr: assert property (p_wr) else $error("drove on write");
  property p_bst; go && write_n ##1 load_advance_n && !clock_gate_n
    ##1 !clock_gate_n ##1 !clock_gate_n |-> ##1 !dq_dev_oe_n; endproperty
  a_bst: assert property (p_bst) else $error("burst beat lost");
  property p_dsel; !clock_gate_n && !load_advance_n && !sel
    ##1 !clock_gate_n ##1 !clock_gate_n |-> ##1 dq_dev_oe_n; endproperty
  a_dsel: assert property (p_dsel) else $error("drove deselected");
  property p_frz; clock_gate_n && !sleep_request |=> $stable(dq_dev_oe_n);
  endproperty
  a_frz: assert property (p_frz) else $error("enable moved");
  property p_frzd; clock_gate_n && !dq_dev_oe_n |=> $stable(dq_dev);
  endproperty
  a_frzd: assert property (p_frzd) else $error("data moved");
  property p_wake; $fell(sleep_request) |-> dq_dev_oe_n ##1 dq_dev_oe_n;
  endproperty
  a_wake: assert property (p_wake) else $error("drove on wake");
  property p_slp; $rose(sleep_request) |-> !sel && !$past(sel); endproperty
  a_slp: assert property (p_slp) else $error("sleep while selected");
endmodule // psp_asserts
`default_nettype wire
